// File: verilog/htc_pkg.sv
package htc_pkg;
  // Timing at the 200 MHz bus clock
  localparam int unsigned CLK_FREQ_KHZ = 200000;
  localparam int unsigned INHIBIT_TIME_MS = 2000;
  localparam int unsigned INHIBIT_CYCLES = INHIBIT_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned STEP_TIME_MS = 10;
  localparam int unsigned STEP_CYCLES = STEP_TIME_MS * CLK_FREQ_KHZ;

  localparam int unsigned N_SENSORS = 4;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SETPOINT = 8'h04;
  localparam logic [7:0] ADDR_DEADBAND = 8'h08;
  localparam logic [7:0] ADDR_PBAND = 8'h0C;
  localparam logic [7:0] ADDR_MIN_AMB = 8'h10;
  localparam logic [7:0] ADDR_PIPE = 8'h14;
  localparam logic [7:0] ADDR_PWR_ADJ = 8'h18;
  localparam logic [7:0] ADDR_AMBIENT = 8'h1C;
  localparam logic [7:0] ADDR_SENSOR0 = 8'h20;
  localparam logic [7:0] ADDR_VALID = 8'h30;
  localparam logic [7:0] ADDR_MEAS_V = 8'h34;
  localparam logic [7:0] ADDR_MEAS_I = 8'h38;
  localparam logic [7:0] ADDR_STATUS = 8'h3C;
  localparam logic [7:0] ADDR_CTRL_TEMP = 8'h40;
  localparam logic [7:0] ADDR_TRACE_V = 8'h44;
  localparam logic [7:0] ADDR_TRACE_I = 8'h48;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_TYPE_LSB = 4;
  localparam int unsigned CTRL_CFG_BIT = 8;
  localparam int unsigned CTRL_DELTA_BIT = 9;
  localparam int unsigned CTRL_LN_BIT = 10;
  localparam int unsigned CTRL_MIN_BIT = 11;

  // Status register fields
  localparam int unsigned ST_REQ = 0;
  localparam int unsigned ST_CONT = 1;
  localparam int unsigned ST_SSR = 2;
  localparam int unsigned ST_INHIB = 3;
  localparam int unsigned ST_CONFLICT = 4;
  localparam int unsigned ST_NOTEMP = 5;
  localparam int unsigned ST_DUTY_LSB = 8;

  // Settings in whole degrees C, signed; power adjust in unsigned percent
  localparam logic signed [15:0] SETPOINT_RST = 16'sh000A;
  localparam logic signed [15:0] SETPOINT_LO = -16'sh00C8;
  localparam logic signed [15:0] SETPOINT_HI = 16'sh02BC;
  localparam logic signed [15:0] DEADBAND_RST = 16'sh0003;
  localparam logic signed [15:0] PBAND_RST = 16'sh0002;
  localparam logic signed [15:0] BAND_MIN = 16'sh0001;
  localparam logic signed [15:0] BAND_MAX = 16'sh0032;
  localparam logic signed [15:0] MIN_AMB_RST = -16'sh0028;
  localparam logic signed [15:0] MIN_AMB_LO = -16'sh0049;
  localparam logic signed [15:0] MIN_AMB_HI = 16'sh0033;
  localparam logic [7:0] PWR_ADJ_RST = 8'h64;
  localparam logic [7:0] PWR_ADJ_MIN = 8'h0A;
  localparam logic [7:0] PWR_ADJ_MAX = 8'hC8;

  localparam logic [6:0] DUTY_FULL = 7'h64;
  localparam logic [6:0] DUTY_LAST = 7'h63;
  localparam logic [9:0] ANALOG_PER_PCT = 10'h00A;
  localparam logic [10:0] SQRT3_Q10 = 11'h6EE;
  localparam logic [10:0] INV_SQRT3_Q10 = 11'h24F;
  localparam int unsigned Q_SHIFT = 10;

  typedef enum logic [2:0] {
    MODE_ONOFF = 3'h0,
    MODE_AMBIENT = 3'h1,
    MODE_PROP = 3'h2,
    MODE_ON = 3'h3,
    MODE_OFF = 3'h4
  } htc_mode_type;

  typedef enum logic [1:0] {
    OUT_CONTACTOR = 2'h0,
    OUT_SSR = 2'h1,
    OUT_ANALOG = 2'h2
  } htc_out_type;

  typedef enum logic [1:0] {
    PIPE_12MM5 = 2'h0,
    PIPE_25MM = 2'h1,
    PIPE_50MM = 2'h2
  } htc_pipe_type;
endpackage

// File: verilog/htc_temp_agg.sv
`timescale 1ns/100ps
module htc_temp_agg (
  input wire logic signed [15:0] temp_in [htc_pkg::N_SENSORS],
  input wire logic [htc_pkg::N_SENSORS-1:0] valid,
  input wire logic use_min,
  output logic signed [15:0] ctrl_temp,
  output logic any_valid
);
  import htc_pkg::*;

  always_comb begin
    logic signed [17:0] sum;
    logic signed [15:0] low;
    logic [2:0] cnt;
    sum = '0;
    low = 16'sh7FFF;
    cnt = '0;
    for (int i = 0; i < N_SENSORS; i++) begin
      if (valid[i]) begin
        sum = sum + 18'(temp_in[i]);
        cnt = cnt + 3'h1;
        if (temp_in[i] < low)
          low = temp_in[i];
      end
    end
    any_valid = (cnt != 3'h0);
    if (cnt == 3'h0)
      ctrl_temp = '0;
    else if (use_min)
      ctrl_temp = low;
    else
      ctrl_temp = 16'(sum / $signed({15'h0000, cnt}));
  end
endmodule

// File: verilog/htc_phase_scale.sv
`timescale 1ns/100ps
module htc_phase_scale (
  input wire logic [15:0] meas_v,
  input wire logic [15:0] meas_i,
  input wire logic delta,
  input wire logic ln_sense,
  output logic [15:0] trace_v,
  output logic [15:0] trace_i
);
  import htc_pkg::*;

  logic [26:0] v_up;
  logic [26:0] v_down;
  logic [26:0] i_down;

  assign v_up = (27'(meas_v) * 27'(SQRT3_Q10)) >> Q_SHIFT;
  assign v_down = (27'(meas_v) * 27'(INV_SQRT3_Q10)) >> Q_SHIFT;
  assign i_down = (27'(meas_i) * 27'(INV_SQRT3_Q10)) >> Q_SHIFT;

  always_comb begin
    if (delta) begin
      trace_i = i_down[15:0];
      // Scaled-up voltage saturates rather than wraps
      if (!ln_sense)
        trace_v = meas_v;
      else if (v_up[26:16] != 11'h000)
        trace_v = 16'hFFFF;
      else
        trace_v = v_up[15:0];
    end else begin
      trace_i = meas_i;
      trace_v = ln_sense ? meas_v : v_down[15:0];
    end
  end
endmodule

// File: verilog/htc_output_ctrl.sv
`timescale 1ns/100ps
module htc_output_ctrl #(
  parameter int unsigned STEP_CYC = htc_pkg::STEP_CYCLES,
  parameter int unsigned INHIBIT_CYC = htc_pkg::INHIBIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ssr_fail,
  output logic contactor_out,
  output logic ssr_out,
  output logic [9:0] analog_level
);
  import htc_pkg::*;

  htc_mode_type mode_ff;
  htc_out_type otype_ff;
  htc_pipe_type pipe_ff;
  logic cfg_ff;
  logic delta_ff;
  logic ln_ff;
  logic aggmin_ff;
  logic signed [15:0] setpoint_ff;
  logic signed [15:0] deadband_ff;
  logic signed [15:0] pband_ff;
  logic signed [15:0] min_amb_ff;
  logic signed [15:0] ambient_ff;
  logic [7:0] pwr_adj_ff;
  logic signed [15:0] sensor_ff [N_SENSORS];
  logic [N_SENSORS-1:0] valid_ff;
  logic [15:0] meas_v_ff;
  logic [15:0] meas_i_ff;
  logic signed [15:0] ctrl_temp_ff;
  logic temp_ok_ff;
  logic [15:0] trace_v_ff;
  logic [15:0] trace_i_ff;
  logic [31:0] step_cnt_ff;
  logic [6:0] step_idx_ff;
  logic [6:0] duty_ff;
  logic [31:0] inhib_cnt_ff;
  logic contactor_ff;
  logic ssr_ff;
  logic [9:0] analog_ff;
  logic fail_meta_ff;
  logic fail_sync_ff;
  logic [31:0] prdata_ff;
  logic err_ff;

  logic wr_en;
  logic signed [15:0] wd16;
  logic signed [15:0] agg_temp;
  logic agg_ok;
  logic [15:0] scaled_v;
  logic [15:0] scaled_i;
  logic [31:0] step_len;
  logic tick;
  logic period_start;
  logic conflict;
  logic heater_req;
  logic [6:0] nxt_duty;
  logic [31:0] nxt_prdata;
  logic nxt_err;

  assign wr_en = psel & penable & pwrite;
  assign wd16 = pwdata[15:0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_ff;
  assign prdata = prdata_ff;
  assign contactor_out = contactor_ff;
  assign ssr_out = ssr_ff;
  assign analog_level = analog_ff;

  htc_temp_agg u_agg (
    .temp_in(sensor_ff),
    .valid(valid_ff),
    .use_min(aggmin_ff),
    .ctrl_temp(agg_temp),
    .any_valid(agg_ok)
  );

  htc_phase_scale u_scale (
    .meas_v(meas_v_ff),
    .meas_i(meas_i_ff),
    .delta(delta_ff),
    .ln_sense(ln_ff),
    .trace_v(scaled_v),
    .trace_i(scaled_i)
  );

  // Out-of-range writes are dropped so settings always stay legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_ONOFF;
      otype_ff <= OUT_CONTACTOR;
      cfg_ff <= 1'b1;
      delta_ff <= 1'b0;
      ln_ff <= 1'b0;
      aggmin_ff <= 1'b0;
      setpoint_ff <= SETPOINT_RST;
      deadband_ff <= DEADBAND_RST;
      pband_ff <= PBAND_RST;
      min_amb_ff <= MIN_AMB_RST;
      pipe_ff <= PIPE_12MM5;
      pwr_adj_ff <= PWR_ADJ_RST;
      ambient_ff <= '0;
      valid_ff <= '0;
      meas_v_ff <= '0;
      meas_i_ff <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: begin
          if (pwdata[CTRL_MODE_LSB +: 3] <= MODE_OFF)
            mode_ff <= htc_mode_type'(pwdata[CTRL_MODE_LSB +: 3]);
          if (pwdata[CTRL_TYPE_LSB +: 2] <= OUT_ANALOG)
            otype_ff <= htc_out_type'(pwdata[CTRL_TYPE_LSB +: 2]);
          cfg_ff <= pwdata[CTRL_CFG_BIT];
          delta_ff <= pwdata[CTRL_DELTA_BIT];
          ln_ff <= pwdata[CTRL_LN_BIT];
          aggmin_ff <= pwdata[CTRL_MIN_BIT];
        end
        ADDR_SETPOINT: if (wd16 >= SETPOINT_LO && wd16 <= SETPOINT_HI)
          setpoint_ff <= wd16;
        ADDR_DEADBAND: if (wd16 >= BAND_MIN && wd16 <= BAND_MAX)
          deadband_ff <= wd16;
        ADDR_PBAND: if (wd16 >= BAND_MIN && wd16 <= BAND_MAX)
          pband_ff <= wd16;
        ADDR_MIN_AMB: if (wd16 >= MIN_AMB_LO && wd16 <= MIN_AMB_HI)
          min_amb_ff <= wd16;
        ADDR_PIPE: if (pwdata[1:0] <= PIPE_50MM)
          pipe_ff <= htc_pipe_type'(pwdata[1:0]);
        ADDR_PWR_ADJ: if (pwdata[7:0] >= PWR_ADJ_MIN && pwdata[7:0] <= PWR_ADJ_MAX
                          && pwdata[31:8] == 24'h000000)
          pwr_adj_ff <= pwdata[7:0];
        ADDR_AMBIENT: ambient_ff <= wd16;
        ADDR_VALID: valid_ff <= pwdata[N_SENSORS-1:0];
        ADDR_MEAS_V: meas_v_ff <= pwdata[15:0];
        ADDR_MEAS_I: meas_i_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  for (genvar g = 0; g < N_SENSORS; g++) begin : g_sensor
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        sensor_ff[g] <= '0;
      else if (wr_en && paddr == ADDR_SENSOR0 + 8'(4 * g))
        sensor_ff[g] <= wd16;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_temp_ff <= '0;
      temp_ok_ff <= 1'b0;
      trace_v_ff <= '0;
      trace_i_ff <= '0;
    end else begin
      ctrl_temp_ff <= agg_temp;
      temp_ok_ff <= agg_ok;
      trace_v_ff <= scaled_v;
      trace_i_ff <= scaled_i;
    end
  end

  // Ambient mode stretches the cycle period with pipe size
  assign step_len = (mode_ff == MODE_AMBIENT) ? (STEP_CYC << pipe_ff) : STEP_CYC;
  assign tick = (step_cnt_ff >= step_len - 32'h1);
  assign period_start = tick && (step_idx_ff == DUTY_LAST);
  assign conflict = (mode_ff == MODE_PROP) && (otype_ff == OUT_CONTACTOR);
  assign heater_req = (step_idx_ff < duty_ff);

  always_comb begin
    logic signed [17:0] err;
    logic signed [17:0] amb_err;
    logic signed [17:0] span;
    logic [6:0] raw;
    logic [14:0] adj;
    raw = 7'h00;
    adj = 15'h0000;
    err = 18'(setpoint_ff) - 18'(ctrl_temp_ff);
    amb_err = 18'(setpoint_ff) - 18'(ambient_ff);
    span = 18'(setpoint_ff) - 18'(min_amb_ff);
    if (amb_err <= 18'sh00000)
      raw = 7'h00;
    else if (span <= 18'sh00000 || amb_err >= span)
      raw = DUTY_FULL;
    else
      raw = 7'((amb_err * 18'sh00064) / span);
    adj = (15'(raw) * 15'(pwr_adj_ff)) / 15'(DUTY_FULL);
    case (mode_ff)
      MODE_ONOFF: nxt_duty = (18'(ctrl_temp_ff) > 18'(setpoint_ff) + 18'(deadband_ff))
                             ? 7'h00 : DUTY_FULL;
      MODE_PROP: begin
        if (err <= 18'sh00000)
          nxt_duty = 7'h00;
        else if (err >= 18'(pband_ff))
          nxt_duty = DUTY_FULL;
        else
          nxt_duty = 7'((err * 18'sh00064) / 18'(pband_ff));
      end
      MODE_AMBIENT: nxt_duty = (adj > 15'(DUTY_FULL)) ? DUTY_FULL : adj[6:0];
      MODE_ON: nxt_duty = DUTY_FULL;
      default: nxt_duty = 7'h00;
    endcase
    // No usable temperature (outside always-on and always-off modes) or illegal pairing forces the heater off
    if (conflict || (!temp_ok_ff && mode_ff != MODE_ON && mode_ff != MODE_OFF))
      nxt_duty = 7'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_ff <= '0;
      step_idx_ff <= '0;
      duty_ff <= '0;
    end else begin
      step_cnt_ff <= tick ? 32'h0 : step_cnt_ff + 32'h1;
      if (tick)
        step_idx_ff <= (step_idx_ff == DUTY_LAST) ? 7'h00 : step_idx_ff + 7'h01;
      if (period_start)
        duty_ff <= nxt_duty;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_meta_ff <= 1'b0;
      fail_sync_ff <= 1'b0;
    end else begin
      fail_meta_ff <= ssr_fail;
      fail_sync_ff <= fail_meta_ff;
    end
  end

  // Contactor moves are rare: the hold-off protects the relay contacts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contactor_ff <= 1'b0;
      inhib_cnt_ff <= '0;
    end else begin
      if (inhib_cnt_ff != 32'h0)
        inhib_cnt_ff <= inhib_cnt_ff - 32'h1;
      if (otype_ff == OUT_CONTACTOR) begin
        if (inhib_cnt_ff == 32'h0 && heater_req != contactor_ff) begin
          contactor_ff <= heater_req;
          inhib_cnt_ff <= INHIBIT_CYC;
        end
      end else begin
        contactor_ff <= cfg_ff & ~fail_sync_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ssr_ff <= 1'b0;
      analog_ff <= '0;
    end else begin
      ssr_ff <= (otype_ff == OUT_SSR) && heater_req;
      analog_ff <= (otype_ff == OUT_ANALOG) ? 10'(duty_ff) * ANALOG_PER_PCT : 10'h000;
    end
  end

  // Read data captured in the setup phase so the access phase needs no wait
  always_comb begin
    nxt_prdata = '0;
    nxt_err = 1'b0;
    case (paddr)
      ADDR_CTRL: nxt_prdata = 32'({aggmin_ff, ln_ff, delta_ff, cfg_ff, 2'h0, otype_ff,
                                   1'b0, mode_ff});
      ADDR_SETPOINT: nxt_prdata = 32'(setpoint_ff);
      ADDR_DEADBAND: nxt_prdata = 32'(deadband_ff);
      ADDR_PBAND: nxt_prdata = 32'(pband_ff);
      ADDR_MIN_AMB: nxt_prdata = 32'(min_amb_ff);
      ADDR_PIPE: nxt_prdata = 32'(pipe_ff);
      ADDR_PWR_ADJ: nxt_prdata = 32'(pwr_adj_ff);
      ADDR_AMBIENT: nxt_prdata = 32'(ambient_ff);
      ADDR_SENSOR0: nxt_prdata = 32'(sensor_ff[0]);
      ADDR_SENSOR0 + 8'h04: nxt_prdata = 32'(sensor_ff[1]);
      ADDR_SENSOR0 + 8'h08: nxt_prdata = 32'(sensor_ff[2]);
      ADDR_SENSOR0 + 8'h0C: nxt_prdata = 32'(sensor_ff[3]);
      ADDR_VALID: nxt_prdata = 32'(valid_ff);
      ADDR_MEAS_V: nxt_prdata = 32'(meas_v_ff);
      ADDR_MEAS_I: nxt_prdata = 32'(meas_i_ff);
      ADDR_STATUS: begin
        nxt_prdata[ST_REQ] = heater_req;
        nxt_prdata[ST_CONT] = contactor_ff;
        nxt_prdata[ST_SSR] = ssr_ff;
        nxt_prdata[ST_INHIB] = (inhib_cnt_ff != 32'h0);
        nxt_prdata[ST_CONFLICT] = conflict;
        nxt_prdata[ST_NOTEMP] = ~temp_ok_ff;
        nxt_prdata[ST_DUTY_LSB +: 7] = duty_ff;
      end
      ADDR_CTRL_TEMP: nxt_prdata = 32'(ctrl_temp_ff);
      ADDR_TRACE_V: nxt_prdata = 32'(trace_v_ff);
      ADDR_TRACE_I: nxt_prdata = 32'(trace_i_ff);
      default: nxt_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
      err_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
      err_ff <= nxt_err;
    end
  end

  onoff_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
    (period_start && mode_ff == MODE_ONOFF && temp_ok_ff && otype_ff != OUT_ANALOG
     && 18'(ctrl_temp_ff) > 18'(setpoint_ff) + 18'(deadband_ff)) |=> duty_ff == 7'h00)
    else $error("on/off duty not cut above setpoint plus deadband");
  band_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    deadband_ff >= BAND_MIN && deadband_ff <= BAND_MAX)
    else $error("deadband out of range");
  prop_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    pband_ff >= BAND_MIN && pband_ff <= BAND_MAX)
    else $error("proportional band out of range");
  prop_conflict_a: assert property (@(posedge pclk) disable iff (!presetn)
    (period_start && conflict) |=> duty_ff == 7'h00 && !heater_req)
    else $error("proportional mode ran on contactor output");
  always_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (period_start && mode_ff == MODE_ON) |=> duty_ff == DUTY_FULL && heater_req)
    else $error("always-on did not request heat");
  always_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (period_start && mode_ff == MODE_OFF) |=> duty_ff == 7'h00 && !heater_req)
    else $error("always-off requested heat");
  contact_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (otype_ff == OUT_CONTACTOR && inhib_cnt_ff != 32'h0) |=> $stable(contactor_ff))
    else $error("contactor changed during hold-off");
  ssr_contact_a: assert property (@(posedge pclk) disable iff (!presetn)
    (otype_ff != OUT_CONTACTOR && !fail_sync_ff) |=> contactor_ff == $past(cfg_ff))
    else $error("contactor left configured state");
  analog_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (otype_ff == OUT_ANALOG) |=> analog_ff == 10'($past(duty_ff)) * ANALOG_PER_PCT)
    else $error("analog level not linear in duty");
  star_current_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!delta_ff) |=> trace_i_ff == $past(meas_i_ff))
    else $error("star trace current differs from measured");
  setpoint_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    setpoint_ff >= SETPOINT_LO && setpoint_ff <= SETPOINT_HI)
    else $error("setpoint out of range");
endmodule

// File: tb/htc_switch_model.sv
`timescale 1ns/100ps
module htc_switch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic contactor_out,
  input wire logic ssr_out,
  input wire logic fail_cmd,
  output logic ssr_fail,
  output logic load_on
);
  // Fail pin moves on the clock; the design still sees it as asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ssr_fail <= 1'b0;
    end else begin
      ssr_fail <= fail_cmd;
    end
  end
  // A failed relay no longer conducts
  assign load_on = contactor_out & ssr_out & !ssr_fail;
endmodule

// File: tb/heat_trace_output_control_test.sv
`timescale 1ns/100ps
module heat_trace_output_control_test;
  import htc_pkg::*;
  localparam int unsigned PER = 200;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rerr, ssr_fail, fail_cmd = 1'b0, contactor_out, ssr_out, load_on;
  logic [9:0] analog_level;
  logic [15:0] lfsr = 16'h000F;
  int n_fail = 0, compares = 0, t, ev, ei, run, mrun, edges;
  logic prev;
  logic [7:0] da [7] = '{ADDR_CTRL, ADDR_SETPOINT, ADDR_DEADBAND, ADDR_PBAND, ADDR_MIN_AMB,
    ADDR_PIPE, ADDR_PWR_ADJ};
  logic [31:0] dv [7] = '{32'h100, 32'hA, 32'h3, 32'h2, 32'hFFFFFFD8, 32'h0, 32'h64};
  logic [7:0] ba [7] = '{ADDR_DEADBAND, ADDR_PBAND, ADDR_MIN_AMB, ADDR_MIN_AMB, ADDR_PWR_ADJ,
    ADDR_PIPE, ADDR_SETPOINT};
  logic [31:0] bv [7] = '{32'h33, 32'h0, 32'h34, 32'hFFFFFFB6, 32'hC9, 32'h3, 32'h2BD};
  int modes [8] = '{0, 0, 2, 2, 2, 3, 4, 0};
  always #2.5 pclk = ~pclk;
  htc_output_ctrl #(.STEP_CYC(2), .INHIBIT_CYC(20)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ssr_fail(ssr_fail),
    .contactor_out(contactor_out), .ssr_out(ssr_out), .analog_level(analog_level));
  htc_switch_model u_sw (.pclk(pclk), .presetn(presetn), .contactor_out(contactor_out),
    .ssr_out(ssr_out), .fail_cmd(fail_cmd), .ssr_fail(ssr_fail), .load_on(load_on));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int model_duty(input int m, input int tc, input int nv);
    int e;
    e = 10 - tc;
    if (m == 3) return 100;
    if (m == 4 || nv == 0) return 0;
    if (m == 0) return (tc > 13) ? 0 : 100;
    if (e <= 0) return 0;
    if (e >= 4) return 100;
    return e * 100 / 4;
  endfunction
  task automatic complete_run();
    $display("Mismatches %0d of %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic defaults();
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, da[k], 32'h0);
      chk(rd, dv[k]);
    end
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    defaults();
    // Out-of-range writes must leave every setting untouched
    for (int k = 0; k < 7; k++) apb(1'b1, ba[k], bv[k]);
    defaults();
    apb(1'b1, ADDR_SETPOINT, 32'hFFFFFF38);
    apb(1'b0, ADDR_SETPOINT, 32'h0);
    chk(rd, 32'hFFFFFF38);
    apb(1'b1, ADDR_SETPOINT, 32'hA);
    apb(1'b1, 8'h80, 32'h1);
    apb(1'b0, 8'h80, 32'h0);
    chk({rd[30:0], rerr}, 32'h1);
    apb(1'b1, ADDR_PBAND, 32'h4);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      t = 3 + lfsr % 12;
      apb(1'b1, ADDR_CTRL, 32'h120 | modes[i]);
      apb(1'b1, ADDR_SENSOR0, 32'(t));
      apb(1'b1, ADDR_VALID, (i == 5) ? 32'h0 : 32'h1);
      repeat (2 * PER + 10) @(posedge pclk);
      chk(analog_level, 10 * model_duty(modes[i], t, i != 5));
    end
    apb(1'b1, ADDR_SENSOR0, 32'h14);
    apb(1'b1, ADDR_SENSOR0 + 8'h04, 32'h4);
    apb(1'b1, ADDR_VALID, 32'h3);
    apb(1'b0, ADDR_CTRL_TEMP, 32'h0);
    chk(rd, 32'hC);
    apb(1'b1, ADDR_CTRL, 32'h904);
    apb(1'b0, ADDR_CTRL_TEMP, 32'h0);
    chk(rd, 32'h4);
    // Lowest temp 4 alone would ask full duty; the pairing must hold it at zero
    apb(1'b1, ADDR_CTRL, 32'h902);
    repeat (PER + 10) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[4], 1'b1);
    chk(rd[14:8], 32'h0);
    // Ambient -39 against minimum -40 gives 98%, a short off gap each period
    apb(1'b1, ADDR_AMBIENT, 32'hFFFFFFD9);
    apb(1'b1, ADDR_CTRL, 32'h101);
    repeat (2 * PER + 10) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[14:8], 32'd98);
    {run, mrun, edges, prev} = {32'd0, 32'd1000, 32'd0, contactor_out};
    repeat (3 * PER) begin
      @(posedge pclk);
      #1;
      if (contactor_out !== prev) begin
        if (edges > 0 && run < mrun) mrun = run;
        edges++;
        run = 0;
        prev = contactor_out;
      end
      run++;
    end
    chk(edges > 1 && mrun >= 21, 1'b1);
    apb(1'b1, ADDR_PWR_ADJ, 32'h32);
    repeat (2 * PER + 10) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[14:8], 32'd49);
    apb(1'b1, ADDR_PIPE, 32'h2);
    apb(1'b0, ADDR_PIPE, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h113);
    repeat (PER + 10) @(posedge pclk);
    chk({contactor_out, ssr_out}, 2'b11);
    fail_cmd <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(contactor_out, 1'b0);
    fail_cmd <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h013);
    repeat (6) @(posedge pclk);
    chk(contactor_out, 1'b0);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, ADDR_MEAS_V, {16'h0, lfsr});
      ev = k[0] ? (k[1] ? (lfsr * 1774) >> 10 : lfsr) : (k[1] ? lfsr : (lfsr * 591) >> 10);
      ev = (ev > 65535) ? 65535 : ev;
      lfsr = lfsr_next(lfsr);
      apb(1'b1, ADDR_MEAS_I, {16'h0, lfsr});
      ei = k[0] ? (lfsr * 591) >> 10 : lfsr;
      apb(1'b1, ADDR_CTRL, 32'h104 | (k << 9));
      apb(1'b0, ADDR_TRACE_V, 32'h0);
      chk(rd, ev);
      apb(1'b0, ADDR_TRACE_I, 32'h0);
      chk(rd, ei);
    end
    complete_run();
  end
endmodule
